// ===== src/swd_defs.svh
// Summary of operation
// - counter advances on separate oscillator ticks
// - time-out triggers configured interrupt or reset
// - restart instruction clears counter before time-out
// - interrupt mode raises request, no reset
// - reset mode expiry asserts system reset
// - combined mode: interrupt first, then reset
// - always-on fuse forces system reset mode
// - fuse locks reset enable one, interrupt zero
// - unlock write sets unlock and reset enable
// - protected change only within four clocks
// - time-out selectable from shortest to longest
// - reference enabled when drop detector enabled
// - reference enabled when routed to comparator
// - software waits reference start-up before use
// - after supervision reset stay in reset or combined mode
// - init software clears cause flag, then enable
// - unlock bit self-clears after four clocks
// - cause flag forces reset enable to one
// - select code doubles count, high codes reserved
// - interrupt flag cleared by vector or write-one
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH
`define SWD_CTRL_BIT_IFLAG   7
`define SWD_CTRL_BIT_IEN     6
`define SWD_CTRL_BIT_SEL3    5
`define SWD_CTRL_BIT_UNLOCK  4
`define SWD_CTRL_BIT_RSTEN   3
`define SWD_CTRL_SEL_LO_MSB  2
`define SWD_ADDR_CTRL        2'h0
`define SWD_ADDR_CAUSE       2'h1
`define SWD_ADDR_CMP         2'h2
`define SWD_ADDR_RESTART     2'h3
`define SWD_CAUSE_BIT_FLAG   3
`define SWD_CMP_BIT_REFSEL   6
`define SWD_UNLOCK_CLOCKS    3'h4
`define SWD_SEL_MAX          4'h9
`define SWD_BASE_SHIFT       11
`define SWD_FUSES_DISABLED   3'h7
`define SWD_BG_START_US      70
`endif

// ===== src/swd_pkg.sv
package swd_pkg;
	typedef logic [1:0] swd_addr_t;
	typedef logic [7:0] swd_data_t;
	typedef enum logic [1:0] {
		SWD_STOPPED,
		SWD_INTR,
		SWD_RESET,
		SWD_INTR_RESET
	} swd_mode_t;
endpackage

// ===== src/swd_link_if.sv
`timescale 1ns/1ps
interface swd_link_if;
	import swd_pkg::*;
	swd_addr_t addr;
	swd_data_t wdata;
	logic      wr;
	logic      rd;
	swd_data_t rdata;
	logic      restart;
	logic      vectorTaken;
	logic      irq;
	logic      sysReset;
	modport device (input addr, wdata, wr, rd, restart, vectorTaken,
		output rdata, irq, sysReset);
	modport core (output addr, wdata, wr, rd, restart, vectorTaken,
		input rdata, irq, sysReset);
endinterface

// ===== src/swd_device.sv
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_device #(
	parameter int CNT_W = 21
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic oscTick,
	input  wire logic alwaysOnFuse_n,
	input  wire logic [2:0] dropLevelFuses,
	output logic      bandgapEnable,
	output swd_pkg::swd_mode_t mode,
	swd_link_if.device link
);
	import swd_pkg::*;

	logic [CNT_W-1:0] count_q;
	logic [3:0]       sel_q;
	logic             rstEn_q;
	logic             intEn_q;
	logic             iFlag_q;
	logic             cause_q;
	logic             refSel_q;
	logic [2:0]       unlockCnt_q;
	logic             sysReset_q;
	swd_data_t        rdata_q;
	logic [CNT_W-1:0] limit;
	logic             fuseOn;
	logic             rstEnEff;
	logic             intEnEff;
	logic             expire;
	logic             ctrlWr;
	logic             unlocked;
	logic             wrUnlock;
	logic [3:0]       wrSel;
	logic             wrRstEn;
	logic             wrIen;
	logic             wrIflag;
	logic             openWr;
	logic             causeWr;
	logic             cmpWr;
	logic             resetFire;
	logic [3:0]       effSel;
	swd_data_t        ctrlView;

	// effective enables, fuse and cause flag override the register bits
	assign fuseOn   = !alwaysOnFuse_n;
	assign rstEnEff = rstEn_q | cause_q | fuseOn;
	assign intEnEff = intEn_q & !fuseOn;
	assign ctrlWr   = link.wr && link.addr == `SWD_ADDR_CTRL;
	assign unlocked = unlockCnt_q != 3'h0;
	assign wrUnlock = link.wdata[`SWD_CTRL_BIT_UNLOCK];
	assign wrSel    = {link.wdata[`SWD_CTRL_BIT_SEL3],
		link.wdata[`SWD_CTRL_SEL_LO_MSB:0]};

	// written field values and the write that an open window accepts
	assign wrRstEn = link.wdata[`SWD_CTRL_BIT_RSTEN];
	assign wrIen   = link.wdata[`SWD_CTRL_BIT_IEN];
	assign wrIflag = link.wdata[`SWD_CTRL_BIT_IFLAG];
	assign openWr  = ctrlWr && unlocked && !wrUnlock;

	// writes to the cause and comparator registers
	assign causeWr = link.wr && link.addr == `SWD_ADDR_CAUSE;
	assign cmpWr   = link.wr && link.addr == `SWD_ADDR_CMP;

	// mode decode, fuse overrides register bits
	always_comb begin
		unique case ({rstEnEff, intEnEff})
			2'b00: mode = SWD_STOPPED;
			2'b01: mode = SWD_INTR;
			2'b10: mode = SWD_RESET;
			2'b11: mode = SWD_INTR_RESET;
		endcase
	end

	// reserved select codes fall back to the longest count
	always_comb begin
		if (sel_q > `SWD_SEL_MAX)
			effSel = `SWD_SEL_MAX;
		else
			effSel = sel_q;
	end

	// time-out count doubles per select step
	always_comb begin
		limit = '0;
		limit[effSel + `SWD_BASE_SHIFT] = 1'b1;
	end

	// expiry on the tick that would reach the time-out count
	assign expire = oscTick && mode != SWD_STOPPED
		&& count_q == limit - 1'b1;

	// counter on oscillator ticks, cleared by restart
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
		end else if (clkEn) begin
			if (link.restart || expire || mode == SWD_STOPPED)
				count_q <= '0;
			else if (oscTick)
				count_q <= count_q + 1'b1;
		end
	end

	// unlock window: four clocks then self-clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unlockCnt_q <= 3'h0;
		end else if (clkEn) begin
			if (ctrlWr && wrUnlock
				&& link.wdata[`SWD_CTRL_BIT_RSTEN])
				unlockCnt_q <= `SWD_UNLOCK_CLOCKS;
			else if (ctrlWr || unlockCnt_q == 3'h1)
				unlockCnt_q <= 3'h0;
			else if (unlocked)
				unlockCnt_q <= unlockCnt_q - 3'h1;
		end
	end

	// protected fields: reset enable clear and select change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstEn_q <= 1'b0;
			sel_q   <= 4'h0;
		end else if (clkEn) begin
			if (cause_q || (ctrlWr && wrRstEn))
				rstEn_q <= 1'b1;
			else if (openWr)
				rstEn_q <= 1'b0;
			if (openWr)
				sel_q <= wrSel;
		end
	end

	// interrupt enable and flag; hardware set wins over clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			intEn_q <= 1'b0;
			iFlag_q <= 1'b0;
		end else if (clkEn) begin
			if (expire && intEnEff)
				iFlag_q <= 1'b1;
			else if ((ctrlWr && wrIflag)
				|| (link.vectorTaken && iFlag_q))
				iFlag_q <= 1'b0;
			if (link.vectorTaken && iFlag_q && rstEnEff)
				intEn_q <= 1'b0;
			else if (ctrlWr)
				intEn_q <= wrIen;
		end
	end

	// reset on expiry, in combined mode only once the flag stands
	assign resetFire = expire && rstEnEff
		&& (!intEnEff || iFlag_q);

	// one-cycle system reset and its cause flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sysReset_q <= 1'b0;
			cause_q    <= 1'b0;
		end else if (clkEn) begin
			sysReset_q <= resetFire;
			if (sysReset_q)
				cause_q <= 1'b1;
			else if (causeWr && !link.wdata[`SWD_CAUSE_BIT_FLAG])
				cause_q <= 1'b0;
		end
	end

	// comparator reference select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			refSel_q <= 1'b0;
		else if (clkEn && cmpWr)
			refSel_q <= link.wdata[`SWD_CMP_BIT_REFSEL];
	end

	// bandgap enable
	assign bandgapEnable = dropLevelFuses != `SWD_FUSES_DISABLED
		|| refSel_q;

	// control register as software sees it
	assign ctrlView = {iFlag_q, intEnEff, sel_q[3], unlocked, rstEnEff,
		sel_q[2:0]};

	// read data, one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else if (clkEn) begin
			rdata_q <= '0;
			if (link.rd) begin
				unique case (link.addr)
					`SWD_ADDR_CTRL: rdata_q <= ctrlView;
					`SWD_ADDR_CAUSE: rdata_q[`SWD_CAUSE_BIT_FLAG] <= cause_q;
					`SWD_ADDR_CMP: rdata_q[`SWD_CMP_BIT_REFSEL] <= refSel_q;
					`SWD_ADDR_RESTART: rdata_q <= '0;
				endcase
			end
		end
	end

	// answers back over the link
	assign link.rdata    = rdata_q;
	assign link.irq      = iFlag_q & intEnEff;
	assign link.sysReset = sysReset_q;
endmodule // swd_device

// ===== src/swd_core.sv
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_core (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  swd_pkg::swd_addr_t usrAddr,
	input  swd_pkg::swd_data_t usrWdata,
	input  wire logic usrWr,
	input  wire logic usrRd,
	input  wire logic usrRestart,
	input  wire logic usrVector,
	output swd_pkg::swd_data_t usrRdata,
	output logic      usrIrq,
	output logic      usrSysReset,
	swd_link_if.core  link
);
	import swd_pkg::*;

	logic restart;

	// restart instruction as a strobe or a write to its address
	assign restart = usrRestart
		|| (usrWr && usrAddr == `SWD_ADDR_RESTART);

	// register and strobe outputs toward the device
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link.addr        <= `SWD_ADDR_CTRL;
			link.wdata       <= '0;
			link.wr          <= 1'b0;
			link.rd          <= 1'b0;
			link.restart     <= 1'b0;
			link.vectorTaken <= 1'b0;
		end else if (clkEn) begin
			link.addr        <= usrAddr;
			link.wdata       <= usrWdata;
			link.wr          <= usrWr && usrAddr != `SWD_ADDR_RESTART;
			link.rd          <= usrRd;
			link.restart     <= restart;
			link.vectorTaken <= usrVector && link.irq;
		end
	end

	// answers passed back to the user side
	assign usrRdata    = link.rdata;
	assign usrIrq      = link.irq;
	assign usrSysReset = link.sysReset;
endmodule // swd_core

// ===== tb/swd_checker.sv
`timescale 1ns/1ps
module swd_checker (
	input wire logic         clk,
	input wire logic         resetn,
	input swd_pkg::swd_addr_t addr,
	input swd_pkg::swd_data_t wdata,
	input wire logic         wr,
	input wire logic         rd,
	input swd_pkg::swd_data_t rdata,
	input wire logic         restart,
	input wire logic         vectorTaken,
	input wire logic         irq,
	input wire logic         sysReset
);
	import swd_pkg::*;
	logic pulse_q;
	logic cause_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shadow of the cause flag, kept two cycles behind the reset pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pulse_q <= 1'b0;
			cause_q <= 1'b0;
		end else begin
			pulse_q <= sysReset;
			if (pulse_q)
				cause_q <= 1'b1;
			else if (wr && addr == 2'h1 && !wdata[3])
				cause_q <= 1'b0;
		end
	end
	chk_reset_pulse: assert property (sysReset |=> !sysReset)
		else $error("reset pulse longer than one cycle");
	chk_read_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside its cycle");
	chk_cause_flag: assert property (rd && addr == 2'h1 && cause_q
		|=> rdata[3]) else $error("cause flag not set");
	chk_enable_forced: assert property (rd && addr == 2'h0 && cause_q
		|=> rdata[3]) else $error("reset enable not forced");
	chk_vector_clear: assert property (vectorTaken |=> !irq)
		else $error("vector left request up");
	chk_write_clear: assert property (wr && addr == 2'h0 && wdata[7]
		|=> !irq) else $error("write one left request up");
	chk_restart_quiet: assert property (restart |-> ##3 !sysReset[*8])
		else $error("reset right after restart");
	chk_irq_no_reset: assert property ($rose(irq) |-> !sysReset[*8])
		else $error("reset beside interrupt");
	cover property (sysReset);
	cover property ($rose(irq));
	cover property (vectorTaken && irq);
endmodule // swd_checker

// ===== tb/swd_watchdog_timer_test.sv
`timescale 1ns/1ps
module swd_watchdog_timer_test;
	import swd_pkg::*;
	logic      clk = 1'b0;
	logic      resetn = 1'b0;
	logic      clkEn = 1'b1;
	logic      oscTick = 1'b1;
	logic      fuseN = 1'b1;
	logic [2:0] dropFuses = 3'h7;
	swd_addr_t addr = 2'h0;
	swd_data_t wdata = 8'h00;
	logic      wr = 1'b0;
	logic      rd = 1'b0;
	logic      restart = 1'b0;
	logic      vector = 1'b0;
	swd_data_t rdata;
	logic      irq;
	logic      sysRst;
	logic      bgEn;
	swd_mode_t mode;
	int        errCount = 0;
	int        nTests = 0;
	int        rstCnt = 0;
	swd_link_if link ();
	swd_device u_swd_device (.clk(clk), .resetn(resetn), .clkEn(clkEn),
		.oscTick(oscTick), .alwaysOnFuse_n(fuseN), .dropLevelFuses(dropFuses),
		.bandgapEnable(bgEn), .mode(mode), .link(link));
	swd_core u_swd_core (.clk(clk), .resetn(resetn), .clkEn(clkEn),
		.usrAddr(addr), .usrWdata(wdata), .usrWr(wr), .usrRd(rd),
		.usrRestart(restart), .usrVector(vector), .usrRdata(rdata),
		.usrIrq(irq), .usrSysReset(sysRst), .link(link));
	swd_checker u_swd_checker (.clk(clk), .resetn(resetn), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
		.restart(link.restart), .vectorTaken(link.vectorTaken),
		.irq(link.irq), .sysReset(link.sysReset));
	// 200 MHz clock and a count of reset pulses
	always #2.5 clk = ~clk;
	always @(posedge clk) if (sysRst === 1'b1) rstCnt++;
	task automatic finalReport();
		if (errCount == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// returns once the device has taken the write, a cycle after the core
	task automatic wrReg(input swd_addr_t a, input swd_data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// read data land two cycles after the strobe, masked compare
	task automatic rdReg(input swd_addr_t a, input swd_data_t m,
		input swd_data_t e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1 chk(rdata & m, e);
	endtask
	task automatic pulse(input logic isVec);
		@(posedge clk);
		if (isVec) vector <= 1'b1; else restart <= 1'b1;
		@(posedge clk);
		vector <= 1'b0;
		restart <= 1'b0;
	endtask
	task automatic waitIrq();
		for (int i = 0; i < 2200 && irq !== 1'b1; i++) @(posedge clk);
		chk({7'h0, irq}, 8'h01);
	endtask
	task automatic waitRst(input int n);
		for (int i = 0; i < 2200 && rstCnt < n; i++) @(posedge clk);
	endtask
	task automatic tBasic();
		rdReg(2'h0, 8'hff, 8'h00);
		chk({7'h0, bgEn}, 8'h00);
		@(posedge clk) dropFuses <= 3'h6;
		#1 chk({7'h0, bgEn}, 8'h01);
		@(posedge clk) dropFuses <= 3'h7;
		wrReg(2'h2, 8'h40);
		cyc(14000);
		#1 chk({7'h0, bgEn}, 8'h01);
		wrReg(2'h2, 8'h00);
	endtask
	task automatic tIntr();
		pulse(1'b0);
		wrReg(2'h0, 8'h40);
		chk({6'h0, mode}, {6'h0, SWD_INTR});
		@(posedge clk) oscTick <= 1'b0;
		cyc(2100);
		chk({7'h0, irq}, 8'h00);
		@(posedge clk) oscTick <= 1'b1;
		waitIrq();
		cyc(8);
		chk(8'(rstCnt), 8'h00);
		pulse(1'b1);
		cyc(1);
		#1 chk({7'h0, irq}, 8'h00);
		wrReg(2'h0, 8'h80);
	endtask
	task automatic tComb();
		pulse(1'b0);
		wrReg(2'h0, 8'h48);
		chk({6'h0, mode}, {6'h0, SWD_INTR_RESET});
		waitIrq();
		chk(8'(rstCnt), 8'h00);
		waitRst(1);
		chk(8'(rstCnt), 8'h01);
		rdReg(2'h1, 8'h08, 8'h08);
		rdReg(2'h0, 8'h08, 8'h08);
		wrReg(2'h0, 8'h88);
	endtask
	task automatic tRestart();
		repeat (6) begin
			pulse(1'b0);
			cyc(1500);
		end
		chk(8'(rstCnt), 8'h01);
	endtask
	task automatic tUnlock();
		pulse(1'b0);
		wrReg(2'h0, 8'h18);
		wrReg(2'h0, 8'h00);
		rdReg(2'h0, 8'h08, 8'h08);
		wrReg(2'h1, 8'h00);
		wrReg(2'h0, 8'h01);
		rdReg(2'h0, 8'h3f, 8'h08);
		wrReg(2'h0, 8'h18);
		cyc(6);
		wrReg(2'h0, 8'h01);
		rdReg(2'h0, 8'h3f, 8'h08);
		wrReg(2'h0, 8'h18);
		wrReg(2'h0, 8'h01);
		rdReg(2'h0, 8'h3f, 8'h01);
		chk({6'h0, mode}, {6'h0, SWD_STOPPED});
	endtask
	task automatic tFuse();
		@(posedge clk) fuseN <= 1'b0;
		wrReg(2'h0, 8'h40);
		chk({6'h0, mode}, {6'h0, SWD_RESET});
		rdReg(2'h0, 8'h48, 8'h08);
		cyc(2100);
		chk(8'(rstCnt), 8'h01);
		waitRst(2);
		chk(8'(rstCnt), 8'h02);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		tBasic();
		tIntr();
		tComb();
		tRestart();
		tUnlock();
		tFuse();
		finalReport();
	end
	// cut a hang short
	initial begin
		#300us;
		errCount++;
		finalReport();
	end
endmodule // swd_watchdog_timer_test
